//--- inc/usfr_pkg.sv
// shared constants for the serial port status, queue level and reset block
package usfr_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [31:0] ADDR_DATA     = 32'h5000_1000;
	localparam logic [31:0] ADDR_STATUS   = 32'h5000_107c;
	localparam logic [31:0] ADDR_TX_FILL  = 32'h5000_1080;
	localparam logic [31:0] ADDR_RX_FILL  = 32'h5000_1084;
	localparam logic [31:0] ADDR_SHADOW   = 32'h5000_1088;
	localparam logic [31:0] ADDR_INT_STAT = 32'h5000_10a0;
	localparam logic [31:0] ADDR_INT_CLR  = 32'h5000_10a4;
	localparam logic [31:0] ADDR_INT_EN   = 32'h5000_10a8;
	localparam logic [31:0] ADDR_DIVISOR  = 32'h5000_10ac;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int SRR_RESET    = 0;
	localparam int SRR_RX_FLUSH = 1;
	localparam int SRR_TX_FLUSH = 2;
	localparam int ST_BUSY      = 0;
	localparam int ST_TX_ROOM   = 1;
	localparam int ST_TX_EMPTY  = 2;
	localparam int ST_RX_NE     = 3;
	localparam int ST_RX_FULL   = 4;
	localparam int INT_TX_DRAIN = 0;
	localparam int INT_RX_DATA  = 1;
	localparam int INT_RX_OVRN  = 2;
	localparam int INT_W        = 3;

	// ----------------------------------------------------------------
	// sizes, reset values and timing
	// ----------------------------------------------------------------
	localparam int          CHAR_W      = 8;
	localparam int          Q_DEPTH     = 16;
	localparam int          CNT_W       = 5;
	localparam int          DIV_W       = 16;
	localparam logic [15:0] DIV_RESET   = 16'h006c;
	localparam logic [3:0]  TICK_LAST   = 4'hf;
	localparam logic [3:0]  TICK_MID    = 4'h7;
	localparam logic [3:0]  BIT_LAST    = 4'h7;
	localparam int          SLOW_STAGES = 3;

	typedef enum logic [1:0] {
		USFR_IDLE  = 2'b00,
		USFR_START = 2'b01,
		USFR_DATA  = 2'b10,
		USFR_STOP  = 2'b11
	} usfr_line_e;

endpackage : usfr_pkg

//--- inc/usfr_q_if.sv
// queue carrier between the controller and its two queues
`timescale 1ns/1ps
`default_nettype none
interface usfr_q_if #(
	parameter int DW = 8,
	parameter int CW = 5
);
	logic          push;
	logic [DW-1:0] wdata;
	logic          pop;
	logic [DW-1:0] rdata;
	logic          flush;
	logic [CW-1:0] count;
	logic          full;
	logic          empty;

	modport fifo (input push, wdata, pop, flush, output rdata, count, full, empty);
	modport user (output push, wdata, pop, flush, input rdata, count, full, empty);
endinterface : usfr_q_if
`default_nettype wire

//--- rtl/usfr_fifo.sv
// character queue with fill count and flush
`timescale 1ns/1ps
`default_nettype none
module usfr_fifo #(
	parameter int DEPTH = 16,
	parameter int DW    = 8,
	parameter int CW    = 5
) (
	input  wire logic pclk,
	input  wire logic rstn,
	usfr_q_if.fifo    q
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [PW-1:0] wptr;
		logic [PW-1:0] rptr;
		logic [CW-1:0] count;
	} usfr_fifo_s;

	usfr_fifo_s     r_reg, r_next;
	logic [DW-1:0]  mem [DEPTH];
	logic           do_push, do_pop;

	// --------------------------------------------------------------
	// pointers; flush only resets control, data stays stale
	// --------------------------------------------------------------
	assign do_push = q.push && !q.full && !q.flush;
	assign do_pop  = q.pop && !q.empty && !q.flush;

	always_comb begin
		r_next = r_reg;
		if (q.flush) begin
			r_next = '0; // queue is treated as empty
		end else begin
			if (do_push) r_next.wptr = r_reg.wptr + 1'b1;
			if (do_pop) r_next.rptr = r_reg.rptr + 1'b1;
			r_next.count = r_reg.count + CW'(do_push) - CW'(do_pop);
		end
	end

	always_ff @(posedge pclk or negedge rstn) begin
		if (!rstn) r_reg <= '0;
		else r_reg <= r_next;
	end

	// storage needs no reset, the count guards it
	always_ff @(posedge pclk) begin
		if (do_push) mem[r_reg.wptr] <= q.wdata;
	end

	assign q.rdata = mem[r_reg.rptr];
	assign q.count = r_reg.count;
	assign q.full  = (r_reg.count == CW'(DEPTH));
	assign q.empty = (r_reg.count == '0);
endmodule : usfr_fifo
`default_nettype wire

//--- rtl/usfr_rst_sync.sv
// software controller reset: asynchronous assert, synchronised release
`timescale 1ns/1ps
`default_nettype none
module usfr_rst_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic soft_req,
	output var  logic core_rstn
);
	logic       req_reg;
	logic       int_rstn;
	logic [1:0] sync_reg;

	// request flop lives on the bus reset only, so it survives its own effect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) req_reg <= 1'b0;
		else req_reg <= soft_req;
	end

	assign int_rstn = presetn & ~req_reg;

	// release is retimed by two flops to avoid recovery hazards
	always_ff @(posedge pclk or negedge int_rstn) begin
		if (!int_rstn) sync_reg <= 2'b00;
		else sync_reg <= {sync_reg[0], 1'b1};
	end

	assign core_rstn = sync_reg[1];
endmodule : usfr_rst_sync
`default_nettype wire

//--- rtl/usfr_top.sv
// serial port controller: status, queue levels, shadow reset, apb slave
`timescale 1ns/1ps
`default_nettype none
// Function
// - transmit room bit is 1 unless the transmit queue is full; resets 1
// - busy bit is 1 during a serial transfer or while the transmit queue holds data, 0 otherwise; resets 0
// - received start counts only at mid bit; busy may read clear before
// - with dual clock option, busy rises after a few slow clock cycles
// - transmit fill register bits 4:0 hold transmit queue entry count
// - receive fill register bits 4:0 hold receive queue entry count
// - shadow bit 2 written 1 flushes the transmit queue
// - shadow bit 1 written 1 flushes the receive queue
// - both flush controls clear themselves after acting
// - shadow bit 0 resets controller asynchronously, release synchronised
// - controller reset covers every clock domain of the controller
// - transmit empty bit is 1 when the transmit queue is empty; resets 1
module usfr_top #(
	parameter bit DUAL_CLOCK = 1'b0
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic        pready,
	output var  logic [31:0] prdata,
	output var  logic        pslverr,
	input  wire logic        qcw_tx_flush,
	input  wire logic        qcw_rx_flush,
	input  wire logic        rxd,
	output var  logic        txd,
	output var  logic        irq
);
	// ----------------------------------------------------------------
	// state record
	// ----------------------------------------------------------------
	// everything the controller remembers besides the queues and the reset flops, registered in one process
	typedef struct packed {
		logic                         pready;
		logic [31:0]                  prdata;
		logic                         pslverr;
		logic [usfr_pkg::DIV_W-1:0]   divisor;
		logic [usfr_pkg::DIV_W-1:0]   tick_cnt;
		logic [usfr_pkg::INT_W-1:0]   int_stat;
		logic [usfr_pkg::INT_W-1:0]   int_en;
		logic                         irq;
		usfr_pkg::usfr_line_e         tx_st;
		logic [3:0]                   tx_sub;
		logic [3:0]                   tx_bit;
		logic [usfr_pkg::CHAR_W-1:0]  tx_shift;
		logic                         txd;
		usfr_pkg::usfr_line_e         rx_st;
		logic [3:0]                   rx_sub;
		logic [3:0]                   rx_bit;
		logic [usfr_pkg::CHAR_W-1:0]  rx_shift;
		logic                         rx_s1;
		logic                         rx_s2;
		logic [usfr_pkg::SLOW_STAGES-1:0] busy_dly;
		logic                         tx_empty_d;
	} usfr_top_s;

	// bus decode, baud timing and queue strobes are all combinational
	usfr_top_s r_reg, r_next;
	logic      core_rstn;
	logic      soft_req;
	logic      setup, access, wr, rd;
	logic      tick, busy_raw, busy;
	logic      tx_push, tx_pop, tx_flush;
	logic      rx_push, rx_pop, rx_flush;
	logic [31:0] rd_mux;
	logic        mapped;
	logic [usfr_pkg::INT_W-1:0] events;

	// one carrier per queue, driven here and answered by the queue
	usfr_q_if #(.DW(usfr_pkg::CHAR_W), .CW(usfr_pkg::CNT_W)) txq ();
	usfr_q_if #(.DW(usfr_pkg::CHAR_W), .CW(usfr_pkg::CNT_W)) rxq ();

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	usfr_rst_sync u_rst (
		.pclk      (pclk),
		.presetn   (presetn),
		.soft_req  (soft_req),
		.core_rstn (core_rstn)
	);

	usfr_fifo #(.DEPTH(usfr_pkg::Q_DEPTH), .DW(usfr_pkg::CHAR_W), .CW(usfr_pkg::CNT_W)) u_txq (
		.pclk (pclk),
		.rstn (core_rstn),
		.q    (txq.fifo)
	);

	usfr_fifo #(.DEPTH(usfr_pkg::Q_DEPTH), .DW(usfr_pkg::CHAR_W), .CW(usfr_pkg::CNT_W)) u_rxq (
		.pclk (pclk),
		.rstn (core_rstn),
		.q    (rxq.fifo)
	);

	// ----------------------------------------------------------------
	// apb phase decode
	// ----------------------------------------------------------------
	// an access is only taken while our own ready stands, so it never repeats
	assign setup  = psel && !penable;
	assign access = psel && penable && r_reg.pready;
	assign wr     = access && pwrite;
	assign rd     = access && !pwrite;

	// shadow writes act for one cycle only, so the controls self-clear
	// the reset request passes one flop before it pulls the core reset
	assign soft_req = wr && (paddr == usfr_pkg::ADDR_SHADOW) && pwdata[usfr_pkg::SRR_RESET];
	assign tx_flush = (wr && (paddr == usfr_pkg::ADDR_SHADOW) && pwdata[usfr_pkg::SRR_TX_FLUSH])
		|| qcw_tx_flush;
	assign rx_flush = (wr && (paddr == usfr_pkg::ADDR_SHADOW) && pwdata[usfr_pkg::SRR_RX_FLUSH])
		|| qcw_rx_flush;

	// data register: write fills transmit queue, read drains receive queue
	assign tx_push = wr && (paddr == usfr_pkg::ADDR_DATA);
	assign rx_pop  = rd && (paddr == usfr_pkg::ADDR_DATA);

	assign txq.push  = tx_push;
	assign txq.wdata = pwdata[usfr_pkg::CHAR_W-1:0];
	assign txq.pop   = tx_pop;
	assign txq.flush = tx_flush;
	assign rxq.push  = rx_push;
	assign rxq.wdata = r_reg.rx_shift; // complete byte by the stop bit, lsb received first
	assign rxq.pop   = rx_pop;
	assign rxq.flush = rx_flush;

	// ----------------------------------------------------------------
	// baud tick and activity flag
	// ----------------------------------------------------------------
	// one tick every divisor cycles; a divisor of zero wraps to the longest period
	assign tick = (r_reg.tick_cnt >= r_reg.divisor - 1'b1);

	// rx only counts as active once the start bit passed its middle
	assign busy_raw = (r_reg.tx_st != usfr_pkg::USFR_IDLE) || !txq.empty
		|| (r_reg.rx_st == usfr_pkg::USFR_DATA) || (r_reg.rx_st == usfr_pkg::USFR_STOP);
	// slow-clock crossing modelled as a delay counted in baud ticks
	// with the option off the flag follows the raw activity at once
	assign busy = DUAL_CLOCK ? (busy_raw && r_reg.busy_dly[usfr_pkg::SLOW_STAGES-1]) : busy_raw;

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	// read data is chosen in the setup cycle and held until the next setup
	// unmapped offsets answer with an error and zero data
	always_comb begin
		rd_mux = '0;
		mapped = 1'b1;
		case (paddr)
			usfr_pkg::ADDR_DATA: rd_mux[usfr_pkg::CHAR_W-1:0] = rxq.rdata;
			usfr_pkg::ADDR_STATUS: begin
				rd_mux[usfr_pkg::ST_BUSY]     = busy;
				rd_mux[usfr_pkg::ST_TX_ROOM]  = !txq.full;
				rd_mux[usfr_pkg::ST_TX_EMPTY] = txq.empty;
				rd_mux[usfr_pkg::ST_RX_NE]    = !rxq.empty;
				rd_mux[usfr_pkg::ST_RX_FULL]  = rxq.full;
			end
			usfr_pkg::ADDR_TX_FILL:  rd_mux[usfr_pkg::CNT_W-1:0] = txq.count;
			usfr_pkg::ADDR_RX_FILL:  rd_mux[usfr_pkg::CNT_W-1:0] = rxq.count;
			usfr_pkg::ADDR_SHADOW:   rd_mux = '0; // write-only
			usfr_pkg::ADDR_INT_STAT: rd_mux[usfr_pkg::INT_W-1:0] = r_reg.int_stat;
			usfr_pkg::ADDR_INT_CLR:  rd_mux = '0;
			usfr_pkg::ADDR_INT_EN:   rd_mux[usfr_pkg::INT_W-1:0] = r_reg.int_en;
			usfr_pkg::ADDR_DIVISOR:  rd_mux[usfr_pkg::DIV_W-1:0] = r_reg.divisor;
			default:                 mapped = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		r_next  = r_reg;
		tx_pop  = 1'b0;
		rx_push = 1'b0;
		events  = '0;

		// bus answer: zero wait states, pready stands one cycle
		r_next.pready = 1'b0;
		if (setup) begin
			r_next.pready  = 1'b1;
			r_next.prdata  = rd_mux;
			r_next.pslverr = !mapped;
		end
		if (wr) begin
			case (paddr)
				usfr_pkg::ADDR_INT_EN:  r_next.int_en = pwdata[usfr_pkg::INT_W-1:0];
				usfr_pkg::ADDR_DIVISOR: r_next.divisor = pwdata[usfr_pkg::DIV_W-1:0];
				default: ;
			endcase
		end

		// baud tick divider
		r_next.tick_cnt = tick ? '0 : r_reg.tick_cnt + 1'b1;

		// activity delay: restarts whenever the raw flag drops
		if (!busy_raw) r_next.busy_dly = '0;
		else if (tick) r_next.busy_dly = {r_reg.busy_dly[usfr_pkg::SLOW_STAGES-2:0], 1'b1};

		// transmitter, sixteen ticks per bit
		case (r_reg.tx_st)
			usfr_pkg::USFR_IDLE: begin
				r_next.txd = 1'b1;
				// a flush in the same cycle wins, so a dropped character is never sent
				if (tick && !txq.empty && !tx_flush) begin
					tx_pop          = 1'b1;
					r_next.tx_shift = txq.rdata;
					r_next.tx_st    = usfr_pkg::USFR_START;
					r_next.tx_sub   = '0;
					r_next.txd      = 1'b0;
				end
			end
			usfr_pkg::USFR_START: begin
				// the start bit lasts a full sixteen ticks before the first data bit
				if (tick) begin
					r_next.tx_sub = r_reg.tx_sub + 1'b1;
					if (r_reg.tx_sub == usfr_pkg::TICK_LAST) begin
						r_next.tx_st  = usfr_pkg::USFR_DATA;
						r_next.tx_bit = '0;
						r_next.txd    = r_reg.tx_shift[0];
					end
				end
			end
			usfr_pkg::USFR_DATA: begin
				if (tick) begin
					r_next.tx_sub = r_reg.tx_sub + 1'b1;
					if (r_reg.tx_sub == usfr_pkg::TICK_LAST) begin
						if (r_reg.tx_bit == usfr_pkg::BIT_LAST) begin
							r_next.tx_st = usfr_pkg::USFR_STOP;
							r_next.txd   = 1'b1;
						end else begin
							r_next.tx_bit   = r_reg.tx_bit + 1'b1;
							r_next.tx_shift = r_reg.tx_shift >> 1;
							r_next.txd      = r_reg.tx_shift[1];
						end
					end
				end
			end
			usfr_pkg::USFR_STOP: begin
				if (tick) begin
					r_next.tx_sub = r_reg.tx_sub + 1'b1;
					if (r_reg.tx_sub == usfr_pkg::TICK_LAST) r_next.tx_st = usfr_pkg::USFR_IDLE;
				end
			end
			default: r_next.tx_st = usfr_pkg::USFR_IDLE;
		endcase

		// receive line synchroniser; only the second flop is looked at
		r_next.rx_s1 = rxd;
		r_next.rx_s2 = r_reg.rx_s1;

		// receiver: start is confirmed only at the middle of the bit
		case (r_reg.rx_st)
			usfr_pkg::USFR_IDLE: begin
				if (tick && !r_reg.rx_s2) begin
					r_next.rx_st  = usfr_pkg::USFR_START;
					r_next.rx_sub = '0;
				end
			end
			usfr_pkg::USFR_START: begin
				if (tick) begin
					r_next.rx_sub = r_reg.rx_sub + 1'b1;
					if (r_reg.rx_sub == usfr_pkg::TICK_MID) begin
						r_next.rx_sub = '0;
						r_next.rx_bit = '0;
						// a glitch shorter than half a bit is dropped
						r_next.rx_st  = r_reg.rx_s2 ? usfr_pkg::USFR_IDLE : usfr_pkg::USFR_DATA;
					end
				end
			end
			usfr_pkg::USFR_DATA: begin
				if (tick) begin
					r_next.rx_sub = r_reg.rx_sub + 1'b1;
					if (r_reg.rx_sub == usfr_pkg::TICK_LAST) begin
						// taken sixteen ticks after the previous bit, near its middle
						r_next.rx_shift = {r_reg.rx_s2, r_reg.rx_shift[usfr_pkg::CHAR_W-1:1]};
						if (r_reg.rx_bit == usfr_pkg::BIT_LAST) r_next.rx_st = usfr_pkg::USFR_STOP;
						else r_next.rx_bit = r_reg.rx_bit + 1'b1;
					end
				end
			end
			usfr_pkg::USFR_STOP: begin
				if (tick) begin
					r_next.rx_sub = r_reg.rx_sub + 1'b1;
					if (r_reg.rx_sub == usfr_pkg::TICK_LAST) begin
						r_next.rx_st = usfr_pkg::USFR_IDLE;
						// stop level is not checked; a flush in this cycle drops the byte
						if (!rx_flush) begin
							rx_push = 1'b1;
							events[usfr_pkg::INT_RX_DATA] = 1'b1;
							events[usfr_pkg::INT_RX_OVRN] = rxq.full; // character lost
						end
					end
				end
			end
			default: r_next.rx_st = usfr_pkg::USFR_IDLE;
		endcase

		// interrupts: a new event wins over a clear in the same cycle
		r_next.tx_empty_d = txq.empty;
		events[usfr_pkg::INT_TX_DRAIN] = txq.empty && !r_reg.tx_empty_d;
		if (wr && (paddr == usfr_pkg::ADDR_INT_CLR))
			r_next.int_stat = r_reg.int_stat & ~pwdata[usfr_pkg::INT_W-1:0];
		r_next.int_stat = r_next.int_stat | events;
		// irq is registered together with the status, both one cycle after their cause
		r_next.irq      = |(r_next.int_stat & r_next.int_en);
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// bus reset and soft reset both land here, so every field restarts together
	always_ff @(posedge pclk or negedge core_rstn) begin
		if (!core_rstn) begin
			r_reg            <= '0;
			r_reg.divisor    <= usfr_pkg::DIV_RESET;
			// line and synchroniser rest high, so no false start follows reset
			r_reg.txd        <= 1'b1;
			r_reg.rx_s1      <= 1'b1;
			r_reg.rx_s2      <= 1'b1;
			r_reg.tx_empty_d <= 1'b1;
			r_reg.tx_st      <= usfr_pkg::USFR_IDLE;
			r_reg.rx_st      <= usfr_pkg::USFR_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// every port is a plain copy of a register field
	assign pready  = r_reg.pready;
	assign prdata  = r_reg.prdata;
	assign pslverr = r_reg.pslverr;
	assign txd     = r_reg.txd;
	assign irq     = r_reg.irq;
endmodule : usfr_top
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the serial status, level and reset block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, err;
	logic        qcw_tx_flush, qcw_rx_flush, rxd, txd, pready, pslverr, irq;
	logic [31:0] paddr, pwdata, prdata, rd;
	int          miscompares, n_tests, cyc;

	usfr_top uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .qcw_tx_flush(qcw_tx_flush),
		.qcw_rx_flush(qcw_rx_flush), .rxd(rxd), .txd(txd), .irq(irq)
	);
	usfr_line_model #(.BIT_CYC(16)) line (.pclk(pclk), .txd(txd), .rxd(rxd));

	// 200 MHz
	always #2.5 pclk = ~pclk;

	// hang guard: the run needs only about a thousand cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			miscompares++;
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// apb transfer; entered right after an edge, leaves one idle cycle behind
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// ready is looked at mid cycle, where it has settled for the coming edge
		do @(negedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd & m, exp);
	endtask : rdc

	task automatic test_done();
		$display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		qcw_tx_flush = 1'b0;
		qcw_rx_flush = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		rdc(usfr_pkg::ADDR_STATUS, 32'h1f, 32'h06);
		rdc(usfr_pkg::ADDR_TX_FILL, 32'hffffffff, 32'h0);
		rdc(usfr_pkg::ADDR_RX_FILL, 32'hffffffff, 32'h0);
		rdc(usfr_pkg::ADDR_SHADOW, 32'hffffffff, 32'h0);
		apb(1'b0, 32'h5000_10f0, 32'h0);
		chk({31'h0, err}, 32'h1);
		// slow reset rate keeps the queue from draining while it is overfilled
		for (int i = 0; i < 18; i++) apb(1'b1, usfr_pkg::ADDR_DATA, 32'(i));
		rdc(usfr_pkg::ADDR_TX_FILL, 32'hffffffff, 32'h10);
		rdc(usfr_pkg::ADDR_STATUS, 32'h7, 32'h1);
		apb(1'b1, usfr_pkg::ADDR_SHADOW, 32'h0);
		rdc(usfr_pkg::ADDR_TX_FILL, 32'hffffffff, 32'h10);
		apb(1'b1, usfr_pkg::ADDR_SHADOW, 32'h4);
		rdc(usfr_pkg::ADDR_STATUS, 32'h6, 32'h6);
		rdc(usfr_pkg::ADDR_TX_FILL, 32'hffffffff, 32'h0);
		apb(1'b1, usfr_pkg::ADDR_DATA, 32'h11);
		rdc(usfr_pkg::ADDR_TX_FILL, 32'hffffffff, 32'h1);
		// fast rate starts the queued character, then a soft reset cuts it
		apb(1'b1, usfr_pkg::ADDR_DIVISOR, 32'h2);
		apb(1'b1, usfr_pkg::ADDR_SHADOW, 32'h1);
		repeat (4) @(posedge pclk);
		rdc(usfr_pkg::ADDR_TX_FILL, 32'hffffffff, 32'h0);
		rdc(usfr_pkg::ADDR_STATUS, 32'h7, 32'h6);
		rdc(usfr_pkg::ADDR_DIVISOR, 32'hffff, 32'h6c);
		apb(1'b1, usfr_pkg::ADDR_DIVISOR, 32'h1);
		// busy stays clear until the start bit is confirmed mid bit
		fork
			line.send(8'h3c);
			begin
				repeat (2) @(posedge pclk);
				rdc(usfr_pkg::ADDR_STATUS, 32'h1, 32'h0);
				repeat (40) @(posedge pclk);
				rdc(usfr_pkg::ADDR_STATUS, 32'h1, 32'h1);
			end
		join
		repeat (16) @(posedge pclk);
		rdc(usfr_pkg::ADDR_RX_FILL, 32'hffffffff, 32'h1);
		// interrupt masked, then enabled, then cleared
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, usfr_pkg::ADDR_INT_EN, 32'h2);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, usfr_pkg::ADDR_INT_CLR, 32'h2);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		rdc(usfr_pkg::ADDR_DATA, 32'hff, 32'h3c);
		line.send(8'h5a);
		line.send(8'hc3);
		repeat (16) @(posedge pclk);
		rdc(usfr_pkg::ADDR_RX_FILL, 32'hffffffff, 32'h2);
		apb(1'b1, usfr_pkg::ADDR_SHADOW, 32'h2);
		rdc(usfr_pkg::ADDR_RX_FILL, 32'hffffffff, 32'h0);
		line.send(8'h77);
		repeat (16) @(posedge pclk);
		qcw_rx_flush <= 1'b1;
		@(posedge pclk);
		qcw_rx_flush <= 1'b0;
		rdc(usfr_pkg::ADDR_RX_FILL, 32'hffffffff, 32'h0);
		// transmit to the partner, then drop the queued rest
		apb(1'b1, usfr_pkg::ADDR_DATA, 32'ha5);
		apb(1'b1, usfr_pkg::ADDR_DATA, 32'h11);
		apb(1'b1, usfr_pkg::ADDR_DATA, 32'h22);
		qcw_tx_flush <= 1'b1;
		@(posedge pclk);
		qcw_tx_flush <= 1'b0;
		rdc(usfr_pkg::ADDR_TX_FILL, 32'hffffffff, 32'h0);
		repeat (200) @(posedge pclk);
		chk({24'h0, line.rx_last}, 32'ha5);
		test_done();
	end
endmodule : tb_top
`default_nettype wire

//--- verif/usfr_assertions.sv
// assertions on the top ports of the serial status, level and reset block
`timescale 1ns/1ps
`default_nettype none
module usfr_assertions (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        qcw_tx_flush,
	input wire logic        qcw_rx_flush,
	input wire logic        rxd,
	input wire logic        txd,
	input wire logic        irq
);
	// ----------------------------------------------------------------
	// shorthands
	// ----------------------------------------------------------------
	// read setup edge, and a shadow write at its access edge
	logic rd_set;
	logic sh_wr;
	assign rd_set = psel && !penable && !pwrite;
	assign sh_wr  = psel && penable && pready && pwrite && paddr == usfr_pkg::ADDR_SHADOW;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	a_ready_one_cycle: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not one cycle after setup");
	a_shadow_reads_zero: assert property (rd_set && paddr == usfr_pkg::ADDR_SHADOW |=> prdata == 32'h0)
		else $error("shadow register read not zero");
	a_tx_fill_range: assert property (rd_set && paddr == usfr_pkg::ADDR_TX_FILL |=>
		prdata[31:5] == 27'h0 && prdata[4:0] <= 5'h10)
		else $error("tx level out of range");
	a_rx_fill_range: assert property (rd_set && paddr == usfr_pkg::ADDR_RX_FILL |=>
		prdata[31:5] == 27'h0 && prdata[4:0] <= 5'h10)
		else $error("rx level out of range");
	// flushes are read back within a few cycles, before any traffic refills
	a_tx_flush_empty: assert property (sh_wr && pwdata[usfr_pkg::SRR_TX_FLUSH] ##[1:8]
		(rd_set && paddr == usfr_pkg::ADDR_TX_FILL) |=> prdata == 32'h0)
		else $error("tx level not zero after flush");
	a_rx_flush_empty: assert property (sh_wr && pwdata[usfr_pkg::SRR_RX_FLUSH] ##[1:8]
		(rd_set && paddr == usfr_pkg::ADDR_RX_FILL) |=> prdata == 32'h0)
		else $error("rx level not zero after flush");
	a_flush_status: assert property (sh_wr && pwdata[usfr_pkg::SRR_TX_FLUSH] ##[1:8]
		(rd_set && paddr == usfr_pkg::ADDR_STATUS) |=>
		prdata[usfr_pkg::ST_TX_ROOM] && prdata[usfr_pkg::ST_TX_EMPTY])
		else $error("tx room or empty not set after flush");
	a_soft_rst_quiet: assert property (sh_wr && pwdata[usfr_pkg::SRR_RESET] |-> ##[1:3] (txd && !irq))
		else $error("line or irq not reset by soft reset");
endmodule : usfr_assertions

bind usfr_top usfr_assertions u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .qcw_tx_flush(qcw_tx_flush),
	.qcw_rx_flush(qcw_rx_flush), .rxd(rxd), .txd(txd), .irq(irq)
);
`default_nettype wire

//--- verif/usfr_line_model.sv
// remote serial device on the line: sends and receives 8n1 characters
`timescale 1ns/1ps
`default_nettype none
module usfr_line_model #(
	parameter int BIT_CYC = 16
) (
	input  wire logic pclk,
	input  wire logic txd,
	output var  logic rxd
);
	logic [7:0] rx_last;

	// idle line is high
	initial begin
		rxd = 1'b1;
		rx_last = 8'h00;
	end

	// one character: start, eight bits lsb first, stop; call right after an edge
	task automatic send(input logic [7:0] ch);
		logic [9:0] fr;
		fr = {1'b1, ch, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= fr[i];
			repeat (BIT_CYC) @(posedge pclk);
		end
	endtask : send

	// sample mid bit so a small rate error on either side is tolerated
	initial forever begin
		@(negedge txd);
		repeat (BIT_CYC / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge pclk);
			rx_last[i] = txd;
		end
	end
endmodule : usfr_line_model
`default_nettype wire
